// File: common/bxl_pkg.sv
// package of the exclusive-access lock block: register map, field positions,
// reset values, pin synchroniser layout and controller states.
// assumes a single 100 MHz clock and the plain register port of the top module.
package bxl_pkg;

	// ==========================================================
	// register offsets (byte addresses on the 8-bit register port)
	localparam logic [7:0] BXL_OFF_CTRL = 8'h00;
	localparam logic [7:0] BXL_OFF_STATUS = 8'h04;
	localparam logic [7:0] BXL_OFF_LOCKST = 8'h08;

	// ==========================================================
	// control register fields
	localparam int BXL_CTRL_SERR_EN = 0;
	localparam int BXL_CTRL_MABORT_MODE = 1;
	localparam int BXL_CTRL_MTO_SERR_EN = 2;
	localparam logic [2:0] BXL_CTRL_RESET = 3'h0;

	// ==========================================================
	// status register fields, write one to clear
	localparam int BXL_STS_SIG_SERR = 0;
	localparam int BXL_STS_RCV_TA = 1;
	localparam int BXL_STS_RCV_MA = 2;
	localparam int BXL_STS_MTO = 3;
	localparam int BXL_STS_W = 4;
	localparam logic [3:0] BXL_STS_RESET = 4'h0;

	// ==========================================================
	// lock state register fields, read only
	localparam int BXL_LST_STATE = 0;
	localparam int BXL_LST_OWN = 4;
	localparam int BXL_LST_RETRY = 5;
	localparam int BXL_LST_FWD_LK = 6;

	// ==========================================================
	// synchronised pin vector layout
	localparam int BXL_SYN_PLOCK = 0;
	localparam int BXL_SYN_PFRAME = 1;
	localparam int BXL_SYN_SLOCK = 2;
	localparam int BXL_SYN_SFRAME = 3;
	localparam int BXL_SYN_SIRDY = 4;
	localparam int BXL_SYN_W = 5;
	localparam logic [4:0] BXL_SYN_RESET = 5'h1f;

	// ==========================================================
	// controller states
	typedef enum logic [3:0] {
		BXL_IDLE,
		BXL_QUEUED,
		BXL_WAIT_SLOCK,
		BXL_ADDR,
		BXL_LOCKING,
		BXL_SEC_HELD,
		BXL_BOTH,
		BXL_PW_END,
		BXL_INIT_ABORT,
		BXL_RELEASE
	} bxl_state_type;

endpackage

// File: design/bxl_req_latch.sv
// holds the captured locked read request and compares repeats against it.
// assumes the capture strobe comes from logic on the same clock.
`timescale 1ns/1ps
module bxl_req_latch (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cap,
	input wire logic [31:0] addr,
	input wire logic [3:0] cmd,
	input wire logic [3:0] be,
	input wire logic par,
	output logic match,
	output logic par_held
);

	typedef struct packed {
		logic [31:0] addr;
		logic [3:0] cmd;
		logic [3:0] be;
		logic par;
	} bxl_latch_type;

	bxl_latch_type r, n;

	always_comb begin
		n = r;
		if (cap) begin
			n.addr = addr;
			n.cmd = cmd;
			n.be = be;
			n.par = par;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// parity is kept but not compared: a repeat is recognised by address,
	// command and byte enables only
	assign match = (addr == r.addr) && (cmd == r.cmd) && (be == r.be);
	assign par_held = r.par;

endmodule

// File: design/bxl_lock_ctrl.sv
// lock handling of the bridge: follows the primary lock pin, owns and drives the
// secondary lock pin, stalls the queues while a locked sequence is in force.
// assumes the bridge core reports bus events as one-cycle pulses on clk and
// that pin levels arrive raw and are synchronised here.
//
// Overview of operation
// [RULE_01] primary and secondary locks stay independent otherwise
// [RULE_02] initiator checks idle bus, lock free
// [RULE_03] lock deasserted in address, asserted next
// [RULE_04] upstream transfers always forwarded unlocked
// [RULE_05] first locked read captured, then retried
// [RULE_06] locked sequence starts with read
// [RULE_07] no prefetch inside locked sequence
// [RULE_08] locked read queued: retry all others
// [RULE_09] earlier queue entries finish before locked read
// [RULE_10] secondary lock: high in address, low after
// [RULE_11] wait for free secondary lock, idle bus
// [RULE_12] secondary then primary lock established
// [RULE_13] initiator repeats with locking sequence
// [RULE_14] master timeout drops read, frees lock
// [RULE_15] later locked transactions forwarded locked
// [RULE_16] abort on first read: report, no lock
// [RULE_17] secondary lock held until primary release
// [RULE_18] retry releases only on first transaction
// [RULE_19] delayed final: release after primary idle
// [RULE_20] posted final: release after secondary write
// [RULE_21] later delayed abort answered with target abort
// [RULE_22] locked posted write abort raises system error
// [RULE_23] system error sets signaled status bit
// [RULE_24] timeout error gated by its own enable
// [RULE_25] reset clears lock, frees secondary pin
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
module bxl_lock_ctrl (
	input wire logic clk,
	input wire logic rstn,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// pins
	input wire logic p_lock_l,
	input wire logic p_frame_l,
	input wire logic s_lock_l_in,
	input wire logic s_frame_l,
	input wire logic s_irdy_l,
	output logic s_lock_l_out,
	output logic s_lock_l_oe,
	output logic p_serr_l_out,
	output logic p_serr_l_oe,
	// downstream request from the primary target side
	input wire logic dn_req,
	input wire logic dn_lock,
	input wire logic dn_read,
	input wire logic [31:0] dn_addr,
	input wire logic [3:0] dn_cmd,
	input wire logic [3:0] dn_be,
	input wire logic dn_par,
	// queue and secondary master events
	input wire logic q_ahead_empty,
	input wire logic s_addr_phase,
	input wire logic s_xfer_done,
	input wire logic s_retry,
	input wire logic s_ta,
	input wire logic s_ma,
	input wire logic dly_ta,
	input wire logic dly_ma,
	input wire logic mto,
	input wire logic pw_pend,
	input wire logic pw_done,
	input wire logic pw_ta,
	input wire logic pw_ma,
	// answers to the bridge core
	output logic rsp_retry,
	output logic rsp_data,
	output logic rsp_ta,
	output logic rsp_ma,
	output logic drop_req,
	output logic sec_req,
	output logic fwd_locked,
	output logic no_prefetch,
	output logic q_hold
);
	import bxl_pkg::*;

	typedef struct packed {
		logic [BXL_SYN_W-1:0] s1;
		logic [BXL_SYN_W-1:0] s2;
		bxl_state_type st;
		logic [2:0] ctrl;
		logic [BXL_STS_W-1:0] sts;
		logic [31:0] rdata;
		logic slk_out;
		logic slk_oe;
		logic serr_oe;
		logic retry;
		logic data;
		logic ta;
		logic ma;
		logic drop;
		logic sreq;
		logic fwd;
		logic nopf;
		logic hold;
		logic init_ta;
		logic ab_pend;
	} bxl_core_type;

	bxl_core_type r, n;
	logic cap;
	logic match;
	logic par_held;
	logic req_lk;
	logic plock_free;
	logic sbus_free;
	logic serr_ev;
	logic [BXL_STS_W-1:0] sts_set;
	logic [BXL_STS_W-1:0] sts_clr;

	bxl_req_latch u_latch (
		.clk(clk),
		.rstn(rstn),
		.cap(cap),
		.addr(dn_addr),
		.cmd(dn_cmd),
		.be(dn_be),
		.par(dn_par),
		.match(match),
		.par_held()
	);

	// ==========================================================
	// pin conditions, read only from the second synchroniser stage
	always_comb begin
		req_lk = dn_req && dn_lock;
		plock_free = r.s2[BXL_SYN_PLOCK] && r.s2[BXL_SYN_PFRAME];
		sbus_free = r.s2[BXL_SYN_SLOCK] && r.s2[BXL_SYN_SFRAME] && r.s2[BXL_SYN_SIRDY];
	end

	// ==========================================================
	// controller
	always_comb begin
		n = r;
		cap = 1'b0;
		serr_ev = 1'b0;
		sts_set = '0;
		n.s1 = {s_irdy_l, s_frame_l, s_lock_l_in, p_frame_l, p_lock_l};
		n.s2 = r.s1;
		n.retry = 1'b0;
		n.data = 1'b0;
		n.ta = 1'b0;
		n.ma = 1'b0;
		n.drop = 1'b0;
		n.serr_oe = 1'b0;
		n.rdata = '0;
		unique case (r.st)
			BXL_IDLE: begin
				// secondary pin left alone: other masters may lock it freely
				n.slk_oe = 1'b0; // [RULE_01]
				n.slk_out = 1'b1; // [RULE_25]
				// a locked write as opener is passed on as plain traffic
				if (req_lk && dn_read) begin // [RULE_06]
					cap = 1'b1; // [RULE_05]
					n.retry = 1'b1; // [RULE_05]
					n.st = BXL_QUEUED;
				end
			end
			BXL_QUEUED: begin
				if (dn_req) begin
					n.retry = 1'b1; // [RULE_08]
				end
				if (q_ahead_empty) begin // [RULE_09]
					n.st = BXL_WAIT_SLOCK;
				end
			end
			BXL_WAIT_SLOCK: begin
				if (dn_req) begin
					n.retry = 1'b1; // [RULE_08]
				end
				// the sampled secondary lock only gates this downstream wait;
				// upstream traffic never looks at it
				if (sbus_free) begin // [RULE_11] [RULE_04]
					n.sreq = 1'b1;
					n.slk_oe = 1'b1;
					n.slk_out = 1'b1; // [RULE_10]
					n.st = BXL_ADDR;
				end
			end
			BXL_ADDR: begin
				if (dn_req) begin
					n.retry = 1'b1; // [RULE_08]
				end
				if (s_addr_phase) begin
					n.sreq = 1'b0;
					n.slk_out = 1'b0; // [RULE_10] [RULE_03]
					n.st = BXL_LOCKING;
				end
			end
			BXL_LOCKING: begin
				if (dn_req) begin
					n.retry = 1'b1; // [RULE_08]
				end
				if (s_xfer_done) begin
					n.st = BXL_SEC_HELD; // [RULE_12]
				end else if (s_ta || s_ma) begin
					n.init_ta = s_ta; // [RULE_16]
					n.slk_out = 1'b1;
					n.st = BXL_INIT_ABORT;
				end else if (s_retry) begin
					// first transaction retried: give the lock back and retry
					n.slk_out = 1'b1; // [RULE_18]
					n.slk_oe = 1'b0;
					n.st = BXL_WAIT_SLOCK;
				end
			end
			BXL_SEC_HELD: begin
				if (mto) begin
					n.drop = 1'b1; // [RULE_14]
					n.slk_out = 1'b1; // [RULE_14]
					sts_set[BXL_STS_MTO] = 1'b1;
					serr_ev = r.ctrl[BXL_CTRL_SERR_EN] && r.ctrl[BXL_CTRL_MTO_SERR_EN]; // [RULE_24]
					n.st = BXL_RELEASE;
				end else if (req_lk && dn_read && match) begin // [RULE_13]
					n.data = 1'b1; // [RULE_12]
					n.st = BXL_BOTH;
				end else if (dn_req) begin
					n.retry = 1'b1; // [RULE_08]
				end
			end
			BXL_BOTH: begin
				n.fwd = 1'b1; // [RULE_15]
				if (dly_ta || dly_ma) begin
					n.ab_pend = 1'b1; // [RULE_21]
					sts_set[BXL_STS_RCV_TA] = dly_ta;
					sts_set[BXL_STS_RCV_MA] = dly_ma;
				end
				if (pw_ta || pw_ma) begin
					sts_set[BXL_STS_RCV_TA] = sts_set[BXL_STS_RCV_TA] | pw_ta;
					sts_set[BXL_STS_RCV_MA] = sts_set[BXL_STS_RCV_MA] | pw_ma;
					serr_ev = r.ctrl[BXL_CTRL_SERR_EN] &&
						(pw_ta || r.ctrl[BXL_CTRL_MABORT_MODE]); // [RULE_22]
				end
				if (req_lk && r.ab_pend) begin
					n.ta = 1'b1; // [RULE_21]
					n.ab_pend = 1'b0;
				end else if (dn_req && !dn_lock) begin
					n.retry = 1'b1; // [RULE_08]
				end
				// secondary retries later in the sequence leave the pin as is
				if (plock_free) begin // [RULE_17] [RULE_18]
					n.fwd = 1'b0;
					if (pw_pend) begin
						n.st = BXL_PW_END;
					end else begin
						n.slk_out = 1'b1; // [RULE_19]
						n.st = BXL_RELEASE;
					end
				end
			end
			BXL_PW_END: begin
				if (dn_req) begin
					n.retry = 1'b1; // [RULE_19]
				end
				if (pw_ta || pw_ma) begin
					sts_set[BXL_STS_RCV_TA] = pw_ta;
					sts_set[BXL_STS_RCV_MA] = pw_ma;
					serr_ev = r.ctrl[BXL_CTRL_SERR_EN] &&
						(pw_ta || r.ctrl[BXL_CTRL_MABORT_MODE]); // [RULE_22]
				end
				if (pw_done) begin
					n.slk_out = 1'b1; // [RULE_20]
					n.st = BXL_RELEASE;
				end
			end
			BXL_INIT_ABORT: begin
				// pin is driven high for the first cycle of this state, then floated while waiting
				n.slk_oe = 1'b0;
				if (req_lk && match) begin
					n.ta = r.init_ta; // [RULE_16]
					n.ma = !r.init_ta;
					sts_set[BXL_STS_RCV_TA] = r.init_ta;
					sts_set[BXL_STS_RCV_MA] = !r.init_ta;
					n.st = BXL_IDLE;
				end else if (dn_req) begin
					n.retry = 1'b1;
				end
			end
			BXL_RELEASE: begin
				// one cycle driven high before floating, then unlocked traffic
				if (dn_req) begin
					n.retry = 1'b1; // [RULE_19]
				end
				n.slk_oe = 1'b0;
				n.ab_pend = 1'b0;
				n.st = BXL_IDLE;
			end
		endcase
		n.nopf = (n.st != BXL_IDLE); // [RULE_07]
		n.hold = (n.st != BXL_IDLE) && (n.st != BXL_INIT_ABORT); // [RULE_08]
		// ======================================================
		// system error pulse and its status bit
		if (serr_ev) begin
			n.serr_oe = 1'b1;
			sts_set[BXL_STS_SIG_SERR] = 1'b1; // [RULE_23]
		end
		// ======================================================
		// register port; set wins over a write-one clear in the same cycle
		sts_clr = '0;
		if (reg_wr && reg_addr == BXL_OFF_CTRL) begin
			n.ctrl = reg_wdata[2:0];
		end
		if (reg_wr && reg_addr == BXL_OFF_STATUS) begin
			sts_clr = reg_wdata[BXL_STS_W-1:0];
		end
		n.sts = (r.sts & ~sts_clr) | sts_set;
		if (reg_rd) begin
			unique case (reg_addr)
				BXL_OFF_CTRL: n.rdata = {29'h0, r.ctrl};
				BXL_OFF_STATUS: n.rdata = {28'h0, r.sts};
				BXL_OFF_LOCKST: n.rdata = {25'h0, r.fwd, r.hold, r.slk_oe, r.st};
				default: n.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
			r.s1 <= BXL_SYN_RESET;
			r.s2 <= BXL_SYN_RESET;
			r.st <= BXL_IDLE; // [RULE_25]
			r.ctrl <= BXL_CTRL_RESET;
			r.sts <= BXL_STS_RESET;
			r.slk_out <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// outputs straight from the state register, except p_serr_l_out which is tied low
	assign reg_rdata = r.rdata;
	assign s_lock_l_out = r.slk_out;
	assign s_lock_l_oe = r.slk_oe;
	assign p_serr_l_out = 1'b0;
	assign p_serr_l_oe = r.serr_oe;
	assign rsp_retry = r.retry;
	assign rsp_data = r.data;
	assign rsp_ta = r.ta;
	assign rsp_ma = r.ma;
	assign drop_req = r.drop;
	assign sec_req = r.sreq;
	assign fwd_locked = r.fwd;
	assign no_prefetch = r.nopf;
	assign q_hold = r.hold;

endmodule

// File: tb/bxl_sec_model.sv
// secondary bus partner: target of the locked read plus one foreign lock holder.
// assumes the bench picks the answer kind, the latency and the foreign lock.
`timescale 1ns/1ps
module bxl_sec_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sec_req,
	input wire logic s_lock_l_out,
	input wire logic s_lock_l_oe,
	input wire logic other_lk,
	input wire logic [1:0] mode,
	input wire logic [3:0] lat,
	output logic s_lock_l_in,
	output logic s_frame_l,
	output logic s_irdy_l,
	output logic s_addr_phase,
	output logic s_xfer_done,
	output logic s_retry,
	output logic s_ta,
	output logic s_ma
);
	int n;
	logic fin;
	// ==========
	// wire and answers
	// pull-up on the lock wire; foreign holder only locks a free bus
	assign s_lock_l_in = s_lock_l_oe ? s_lock_l_out : !other_lk;
	assign s_frame_l = !other_lk;
	assign s_irdy_l = !other_lk;
	assign fin = n == int'(lat) + 2;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			n <= 0;
			{s_addr_phase, s_xfer_done, s_ta, s_ma, s_retry} <= 5'h0;
		end else begin
			s_addr_phase <= sec_req && n == 0;
			// mode 0 completes, 1 target abort, 2 master abort, 3 retry
			{s_xfer_done, s_ta, s_ma, s_retry} <= fin ? 4'h8 >> mode : 4'h0;
			n <= fin ? 0 : (n > 0 || sec_req) ? n + 1 : 0;
		end
	end
endmodule

// File: tb/bxl_chk.sv
// port assertions of the lock controller.
// assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
module bxl_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic s_lock_l_in,
	input wire logic s_frame_l,
	input wire logic s_irdy_l,
	input wire logic dn_req,
	input wire logic dn_lock,
	input wire logic s_addr_phase,
	input wire logic mto,
	input wire logic pw_ta,
	input wire logic pw_ma,
	input wire logic s_lock_l_out,
	input wire logic s_lock_l_oe,
	input wire logic p_serr_l_oe,
	input wire logic rsp_retry,
	input wire logic rsp_data,
	input wire logic drop_req,
	input wire logic sec_req,
	input wire logic fwd_locked,
	input wire logic no_prefetch,
	input wire logic q_hold
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// ==========
	// port properties
	chk_retry_first: assert property ($rose(q_hold) |-> rsp_retry && no_prefetch)
		else $error("queued read not retried");
	chk_plain_retry: assert property (q_hold && dn_req && !dn_lock |=> rsp_retry)
		else $error("request passed a held queue");
	// synchroniser: decision sees the wire two edges late
	chk_wait_free: assert property ($rose(sec_req) |->
		$past(s_lock_l_in, 3) && $past(s_frame_l, 3) && $past(s_irdy_l, 3))
		else $error("secondary requested while busy");
	chk_lock_addr: assert property ($rose(s_lock_l_oe) |-> s_lock_l_out && sec_req)
		else $error("lock low in address phase");
	chk_lock_low: assert property (s_addr_phase && sec_req |=> !s_lock_l_out)
		else $error("lock not asserted after address");
	chk_mto_drop: assert property (drop_req |->
		$past(mto) && s_lock_l_out ##1 !s_lock_l_oe)
		else $error("timeout release wrong");
	chk_serr_cause: assert property ($rose(p_serr_l_oe) |-> $past(mto || pw_ta || pw_ma))
		else $error("system error without cause");
	chk_fwd_both: assert property ($rose(fwd_locked) |-> $past(rsp_data))
		else $error("locked forwarding too early");
	chk_keep_lock: assert property (fwd_locked |-> s_lock_l_oe && !s_lock_l_out)
		else $error("lock lost while held");
	chk_reset_free: assert property (!$past(rstn) |->
		s_lock_l_out && !s_lock_l_oe && !sec_req)
		else $error("lock left after reset");
	cov_both: cover property ($rose(fwd_locked));
	cov_mto: cover property (drop_req && p_serr_l_oe);
	cov_free: cover property ($fell(s_lock_l_oe));
endmodule
bind bxl_lock_ctrl bxl_chk i_chk (
	.clk(clk),
	.rstn(rstn),
	.s_lock_l_in(s_lock_l_in),
	.s_frame_l(s_frame_l),
	.s_irdy_l(s_irdy_l),
	.dn_req(dn_req),
	.dn_lock(dn_lock),
	.s_addr_phase(s_addr_phase),
	.mto(mto),
	.pw_ta(pw_ta),
	.pw_ma(pw_ma),
	.s_lock_l_out(s_lock_l_out),
	.s_lock_l_oe(s_lock_l_oe),
	.p_serr_l_oe(p_serr_l_oe),
	.rsp_retry(rsp_retry),
	.rsp_data(rsp_data),
	.drop_req(drop_req),
	.sec_req(sec_req),
	.fwd_locked(fwd_locked),
	.no_prefetch(no_prefetch),
	.q_hold(q_hold)
);

// File: tb/tb.sv
// bench of the lock controller with its secondary partner, checked against fixed expected values.
// assumes package, controller, partner and checker compile first.
`timescale 1ns/1ps
`define CHK(e, g, n) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected %s exp %0h got %0h", n, e, g); end end
`define WT(c) begin repeat (80) if (!(c)) @(negedge clk); if (!(c)) begin mismatches++; \
	$display("unexpected wait exp 1 got 0"); end end
module tb;
	import bxl_pkg::*;
	logic clk = 0;
	logic rstn = 0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [7:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0;
	logic [31:0] dn_addr = 0;
	logic [3:0] dn_cmd = 0;
	logic [3:0] dn_be = 0;
	logic [3:0] lat = 0;
	logic [1:0] mode = 0;
	logic p_lock_l = 1;
	logic p_frame_l = 1;
	logic dn_req = 0, dn_lock = 0, dn_read = 0, dn_par = 0, q_ahead_empty = 1, other_lk = 0;
	logic dly_ta = 0, dly_ma = 0, mto = 0, pw_pend = 0, pw_done = 0, pw_ta = 0, pw_ma = 0;
	wire [31:0] reg_rdata;
	wire s_lock_l_in, s_frame_l, s_irdy_l, s_addr_phase, s_xfer_done, s_retry, s_ta, s_ma;
	wire s_lock_l_out, s_lock_l_oe, p_serr_l_out, p_serr_l_oe, rsp_retry, rsp_data, rsp_ta;
	wire rsp_ma, drop_req, sec_req, fwd_locked, no_prefetch, q_hold;
	int mismatches = 0;
	int n_checks = 0;
	int c;
	logic [31:0] a;
	logic [31:0] d;
	bxl_lock_ctrl i_dut (.*);
	bxl_sec_model i_sec (.*);
	initial begin
		forever #5 clk = ~clk;
	end
	// ==========
	// bus and event tasks
	task wr(logic [7:0] ad, logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= ad;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	task rd(logic [7:0] ad, logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= ad;
		@(posedge clk);
		reg_rd <= 0;
		@(negedge clk);
		`CHK(e, reg_rdata, "reg")
	endtask
	// answer code: retry 8, data 4, target abort 2, master abort 1
	task req(logic l, logic r, logic [31:0] ad, logic [3:0] e);
		@(posedge clk);
		dn_req <= 1;
		dn_lock <= l;
		dn_read <= r;
		dn_addr <= ad;
		dn_cmd <= r ? 4'h6 : 4'h7;
		dn_be <= ad[3:0];
		dn_par <= ^ad;
		@(posedge clk);
		dn_req <= 0;
		@(negedge clk);
		`CHK(e, {rsp_retry, rsp_data, rsp_ta, rsp_ma}, "rsp")
	endtask
	task pls(int i);
		@(posedge clk);
		{mto, pw_ta, pw_ma, pw_done, dly_ma, dly_ta} <= 6'h20 >> i;
		@(posedge clk);
		{mto, pw_ta, pw_ma, pw_done, dly_ma, dly_ta} <= 6'h0;
		@(negedge clk);
	endtask
	task lock_up(logic [1:0] m);
		mode <= m;
		lat <= 4'($urandom_range(9));
		a = $urandom;
		req(1, 1, a, 8);
		`WT(s_xfer_done || s_ta || s_ma || s_retry)
	endtask
	// primary lock goes low ahead of the repeat: the release check sees the pin two edges late
	task both;
		p_lock_l <= 0;
		req(1, 1, a, 4);
		@(negedge clk);
		`CHK(1, fwd_locked, "fwd")
	endtask
	// frame still low: the lock must survive until the bus is idle
	task rel;
		p_lock_l <= 1;
		p_frame_l <= 0;
		repeat (6) @(negedge clk);
		`CHK(1, s_lock_l_oe, "hold")
		p_frame_l <= 1;
	endtask
	task complete_run;
		if (mismatches == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#300us;
		mismatches++;
		complete_run;
	end
	// ==========
	// scenarios
	initial begin
		void'($urandom(91841));
		repeat (3) @(posedge clk);
		rstn <= 1;
		rd(BXL_OFF_CTRL, 0);
		rd(BXL_OFF_STATUS, 0);
		rd(BXL_OFF_LOCKST, 0);
		d = $urandom;
		wr(BXL_OFF_CTRL, d);
		rd(BXL_OFF_CTRL, d & 7);
		wr(8'h0c, d);
		rd(8'h0c, 0);
		req(1, 0, d, 0);
		`CHK(0, q_hold, "qhold")
		for (c = 0; c < 8; c++) begin
			wr(BXL_OFF_CTRL, c);
			lock_up(0);
			pls(0);
			`CHK(1, drop_req, "drop")
			`CHK(c[0] & c[2], p_serr_l_oe, "serr")
			`WT(!s_lock_l_oe)
			rd(BXL_OFF_STATUS, 8 | (c[0] & c[2]));
			wr(BXL_OFF_STATUS, 32'hf);
		end
		wr(BXL_OFF_CTRL, 1);
		other_lk <= 1;
		q_ahead_empty <= 0;
		a = $urandom;
		req(1, 1, a, 8);
		`CHK(1, no_prefetch, "npf")
		req(0, 1, ~a, 8);
		repeat (8) @(negedge clk);
		`CHK(0, sec_req, "sreq")
		q_ahead_empty <= 1;
		repeat (8) @(negedge clk);
		`CHK(0, sec_req, "sreq")
		other_lk <= 0;
		`WT(s_xfer_done)
		req(1, 1, a ^ 16, 8);
		both;
		rd(BXL_OFF_LOCKST, 32'h76);
		req(0, 1, a, 8);
		req(1, 0, a, 0);
		pls(1);
		`CHK(1, p_serr_l_oe, "serr")
		rel;
		`WT(!s_lock_l_oe)
		rd(BXL_OFF_LOCKST, 0);
		rd(BXL_OFF_STATUS, 3);
		wr(BXL_OFF_STATUS, 32'hf);
		lock_up(0);
		both;
		pw_pend <= 1;
		pls(2);
		`CHK(0, p_serr_l_oe, "serr")
		wr(BXL_OFF_CTRL, 3);
		pls(2);
		`CHK(1, p_serr_l_oe, "serr")
		rel;
		repeat (4) @(negedge clk);
		`CHK(1, s_lock_l_oe, "hold")
		pls(3);
		pw_pend <= 0;
		`WT(!s_lock_l_oe)
		rd(BXL_OFF_STATUS, 5);
		wr(BXL_OFF_STATUS, 32'hf);
		lock_up(0);
		both;
		pls(4);
		req(1, 1, a, 2);
		pls(5);
		req(1, 1, a, 2);
		p_lock_l <= 1;
		`WT(!s_lock_l_oe)
		rd(BXL_OFF_STATUS, 6);
		wr(BXL_OFF_STATUS, 32'hf);
		for (c = 1; c < 4; c++) begin
			lock_up(c);
			mode <= 0;
			@(negedge clk);
			`CHK(c < 3, s_lock_l_oe, "oe")
			`WT(!s_lock_l_oe)
			if (c < 3) begin
				req(1, 1, a, 4 >> c);
				rd(BXL_OFF_STATUS, 1 << c);
				wr(BXL_OFF_STATUS, 32'hf);
			end else begin
				`WT(s_xfer_done)
				both;
				rel;
				`WT(!s_lock_l_oe)
			end
		end
		rd(BXL_OFF_LOCKST, 0);
		// reset while both locks are held must free the secondary pin
		lock_up(0);
		both;
		rstn <= 0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		p_lock_l <= 1;
		@(negedge clk);
		`CHK(1, s_lock_l_out, "out")
		`CHK(0, s_lock_l_oe, "oe")
		rd(BXL_OFF_LOCKST, 0);
		complete_run;
	end
endmodule
